// file: inc/pcw_pkg.sv
// Purpose: Shared constants and types for the counter array compare/PWM/watchdog block
// Assumes: One clock, synchronous active-low reset
// Notes:   Mode register fields are packed into a 5-bit control word
`default_nettype none

package pcw_pkg;

    // Counter array geometry
    localparam int unsigned CNT_W       = 16;
    localparam int unsigned BYTE_W      = 8;
    localparam int unsigned NUM_MOD     = 3;
    localparam int unsigned SEL_W       = 2;
    localparam logic [1:0]  WDT_MOD     = 2'h2;

    // Module mode register field positions
    localparam int unsigned MODE_W      = 5;
    localparam int unsigned MODE_CEN    = 0;
    localparam int unsigned MODE_MAT    = 1;
    localparam int unsigned MODE_PULSE  = 2;
    localparam int unsigned MODE_P16    = 3;
    localparam int unsigned MODE_IE     = 4;

    // Reset values and counter maximums
    localparam logic [MODE_W-1:0] MODE_RST      = 5'h00;
    localparam logic [15:0]       CNT_RST       = 16'h0000;
    localparam logic [15:0]       CMP_RST       = 16'h0000;
    localparam logic [15:0]       CNT_MAX       = 16'hFFFF;
    localparam logic [7:0]        BYTE_MAX      = 8'hFF;
    localparam logic              WDT_EN_RST    = 1'b1;
    localparam logic [7:0]        WDT_OFS_RST   = 8'hFF;
    localparam logic [7:0]        WDT_MATCH_RST = 8'hFF;

    // Operating mode of one module
    typedef enum logic [1:0] {
        PCW_OFF,
        PCW_TIMER,
        PCW_PWM16,
        PCW_WDOG
    } pcw_mode_t;

    // Decode a mode word into the operating mode
    function automatic pcw_mode_t pcw_decode(input logic [MODE_W-1:0] m,
                                             input logic               wdog);
        pcw_mode_t r;
        r = PCW_OFF;
        if (wdog) begin
            r = PCW_WDOG;
        end else if (m[MODE_CEN] && m[MODE_PULSE] && m[MODE_P16]) begin
            r = PCW_PWM16;
        end else if (m[MODE_CEN] && m[MODE_MAT]) begin
            r = PCW_TIMER;
        end
        return r;
    endfunction

endpackage : pcw_pkg

`default_nettype wire

// file: hw/pcw_wdt.sv
// Purpose: Watchdog held in module 2 of the counter array
// Assumes: Counter value supplied by the array, update strobe from software
// Notes:   Reset pulse is one cycle wide and comes from a flop
`default_nettype none

module pcw_wdt
    import pcw_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_b_in,
    // Control
    input  wire logic              wdt_on_in,
    input  wire logic              update_in,
    input  wire logic              offset_wr_in,
    input  wire logic [BYTE_W-1:0] offset_in,
    input  wire logic [CNT_W-1:0]  cnt_in,
    // Result
    output logic                   wdt_reset_out,
    output logic [BYTE_W-1:0]      match_out
);

    logic [BYTE_W-1:0] offset_q;
    logic [BYTE_W-1:0] match_q;
    logic              trip_d;

    // Offset byte stored only while the watchdog is off
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            offset_q <= WDT_OFS_RST;
        end else if (offset_wr_in && !wdt_on_in) begin
            offset_q <= offset_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            match_q <= WDT_MATCH_RST;
        end else if (update_in) begin
            match_q <= cnt_in[CNT_W-1:BYTE_W] + offset_q;
        end
    end

    // High byte compare
    // Trip when the counter high byte steps onto the match value
    assign trip_d = wdt_on_in && !update_in
                    && (cnt_in[BYTE_W-1:0] == BYTE_MAX)
                    && (cnt_in[CNT_W-1:BYTE_W] + 8'h01 == match_q);

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            wdt_reset_out <= 1'b0;
        end else begin
            wdt_reset_out <= trip_d;
        end
    end

    assign match_out = match_q;

endmodule : pcw_wdt

`default_nettype wire

// file: hw/pcw_core.sv
// Purpose: Counter array with compare, 16-bit PWM and watchdog modules
// Assumes: Register writes arrive as one-cycle strobes synchronous to clk_in
// Notes:   Module 2 becomes the watchdog while the enable bit is set
`default_nettype none

module pcw_core
    import pcw_pkg::*;
#(
    parameter int unsigned N_MOD = NUM_MOD
) (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_b_in,
    // Software writes
    input  wire logic [SEL_W-1:0]  mod_sel_in,
    input  wire logic [BYTE_W-1:0] wr_data_in,
    input  wire logic              wr_cmp_low_in,
    input  wire logic              wr_cmp_high_in,
    input  wire logic              wr_mode_in,
    input  wire logic [MODE_W-1:0] mode_data_in,
    input  wire logic              wr_wdt_en_in,
    input  wire logic              wdt_en_data_in,
    input  wire logic              flag_clr_in,
    input  wire logic              ovf_clr_in,
    // Status
    output logic [CNT_W-1:0]       counter_out,
    output logic [N_MOD-1:0]       module_match_flag_out,
    output logic                   overflow_flag_out,
    output logic                   irq_out,
    output logic                   watchdog_enable_bit_out,
    // Pins and reset request
    output logic [N_MOD-1:0]       module_output_pin_out,
    output logic                   wdt_reset_out
);

    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;
    logic              wrap_d;
    logic [CNT_W-1:0]  cmp_q [N_MOD];
    logic [MODE_W-1:0] mode_q [N_MOD];
    logic [N_MOD-1:0]  flag_q;
    logic [N_MOD-1:0]  pin_q;
    logic              ovf_q;
    logic              irq_q;
    logic              wdt_on_q;
    logic              wdt_update;
    logic              wdt_ofs_wr;
    logic [BYTE_W-1:0] wdt_match;
    logic [N_MOD-1:0]  hit;
    logic [N_MOD-1:0]  mod_wdog;
    logic [N_MOD-1:0]  locked;
    pcw_mode_t         mode_now [N_MOD];
    logic [N_MOD-1:0]  sel_hit;
    logic [N_MOD-1:0]  cen_bit;
    logic [N_MOD-1:0]  mat_bit;
    logic [N_MOD-1:0]  ie_bit;
    logic [N_MOD-1:0]  pwm_on;
    logic [N_MOD-1:0]  tmr_on;
    logic [N_MOD-1:0]  flag_d;
    logic [N_MOD-1:0]  pin_d;
    logic              irq_d;

    // Decode of the module select for per-module writes
    function automatic logic sel_is(input logic [SEL_W-1:0] sel,
                                    input int               idx);
        logic r;
        r = (sel == SEL_W'(idx));
        return r;
    endfunction

    assign cnt_d  = cnt_q + 16'h0001;
    assign wrap_d = (cnt_q == CNT_MAX);

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cnt_q <= CNT_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Overflow flag, set wins over clear
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ovf_q <= 1'b0;
        end else if (wrap_d) begin
            ovf_q <= 1'b1;
        end else if (ovf_clr_in) begin
            ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            wdt_on_q <= WDT_EN_RST;
        end else if (wr_wdt_en_in) begin
            wdt_on_q <= wdt_en_data_in;
        end
    end

    // Per-module decode
    always_comb begin
        for (int i = 0; i < N_MOD; i++) begin
            mod_wdog[i] = wdt_on_q && (i == int'(WDT_MOD));
            locked[i]   = mod_wdog[i];
            mode_now[i] = pcw_decode(mode_q[i], mod_wdog[i]);
            hit[i]      = (cnt_q == cmp_q[i]);
        end
    end

    // Module select decode
    always_comb begin
        for (int i = 0; i < N_MOD; i++) begin
            sel_hit[i] = sel_is(mod_sel_in, i);
        end
    end

    // Mode bit views per module
    always_comb begin
        for (int i = 0; i < N_MOD; i++) begin
            cen_bit[i] = mode_q[i][MODE_CEN];
            mat_bit[i] = mode_q[i][MODE_MAT];
            ie_bit[i]  = mode_q[i][MODE_IE];
            pwm_on[i]  = (mode_now[i] == PCW_PWM16);
            tmr_on[i]  = !mod_wdog[i] && cen_bit[i] && mat_bit[i];
        end
    end

    // Watchdog strobes: an update only counts while the watchdog runs,
    // the offset write is refused inside the watchdog while it runs
    assign wdt_update = wdt_on_q && wr_cmp_high_in && (mod_sel_in == WDT_MOD);
    assign wdt_ofs_wr = wr_cmp_low_in && (mod_sel_in == WDT_MOD);

    // Compare value byte writes
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < N_MOD; i++) begin
                cmp_q[i] <= CMP_RST;
            end
        end else begin
            for (int i = 0; i < N_MOD; i++) begin
                if (sel_hit[i] && !locked[i]) begin
                    if (wr_cmp_low_in) begin
                        cmp_q[i][BYTE_W-1:0] <= wr_data_in;
                    end
                    if (wr_cmp_high_in) begin
                        cmp_q[i][CNT_W-1:BYTE_W] <= wr_data_in;
                    end
                end
            end
        end
    end

    // Mode register with comparator enable side effects
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < N_MOD; i++) begin
                mode_q[i] <= MODE_RST;
            end
        end else begin
            for (int i = 0; i < N_MOD; i++) begin
                if (sel_hit[i] && !locked[i]) begin
                    if (wr_mode_in) begin
                        mode_q[i] <= mode_data_in;
                    end else if (wr_cmp_low_in) begin
                        mode_q[i][MODE_CEN] <= 1'b0;
                    end else if (wr_cmp_high_in) begin
                        mode_q[i][MODE_CEN] <= 1'b1;
                    end
                end
            end
        end
    end

    // Match flags, a match in the clear cycle still sets
    always_comb begin
        flag_d = flag_q;
        for (int i = 0; i < N_MOD; i++) begin
            if (tmr_on[i] && hit[i]) begin
                flag_d[i] = 1'b1;
            end else if (flag_clr_in && sel_hit[i]) begin
                flag_d[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    always_comb begin
        irq_d = 1'b0;
        for (int i = 0; i < N_MOD; i++) begin
            if (flag_q[i] && ie_bit[i] && !mod_wdog[i]) begin
                irq_d = 1'b1;
            end
        end
    end

    // Interrupt request, one cycle behind the flags
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // PWM pin next value, tested against the next counter value
    // so the pin changes on the same edge as counter_out
    always_comb begin
        pin_d = pin_q;
        for (int i = 0; i < N_MOD; i++) begin
            if (!pwm_on[i]) begin
                pin_d[i] = 1'b0;
            end else if (cnt_d == cmp_q[i]) begin
                pin_d[i] = 1'b1;
            end else if (wrap_d) begin
                pin_d[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pin_q <= '0;
        end else begin
            pin_q <= pin_d;
        end
    end

    // Watchdog instance
    // Module 2 compare bytes double as watchdog update and offset
    pcw_wdt i_pcw_wdt (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .wdt_on_in     (wdt_on_q),
        .update_in     (wdt_update),
        .offset_wr_in  (wdt_ofs_wr),
        .offset_in     (wr_data_in),
        .cnt_in        (cnt_q),
        .wdt_reset_out (wdt_reset_out),
        .match_out     (wdt_match)
    );

    // Counter and status
    assign counter_out             = cnt_q;
    assign module_match_flag_out   = flag_q;
    assign overflow_flag_out       = ovf_q;
    assign irq_out                 = irq_q;

    // Watchdog enable and pins
    assign watchdog_enable_bit_out = wdt_on_q;
    assign module_output_pin_out   = pin_q;

endmodule : pcw_core

`default_nettype wire

// file: test/pcw_core_checker.sv
// Purpose: Port-level assertions for pcw_core
// Assumes: Module 0 compare and mode are shadowed from write strobes
// Notes:   Bound to every pcw_core instance
`default_nettype none

module pcw_core_checker
    import pcw_pkg::*;
#(
    parameter int unsigned N_MOD = NUM_MOD
) (
    // Clock, reset and writes
    input wire logic              clk_in,
    input wire logic              rst_b_in,
    input wire logic [SEL_W-1:0]  mod_sel_in,
    input wire logic [BYTE_W-1:0] wr_data_in,
    input wire logic              wr_cmp_low_in,
    input wire logic              wr_cmp_high_in,
    input wire logic              wr_mode_in,
    input wire logic [MODE_W-1:0] mode_data_in,
    input wire logic              flag_clr_in,
    // Design outputs
    input wire logic [CNT_W-1:0]  counter_out,
    input wire logic [N_MOD-1:0]  module_match_flag_out,
    input wire logic              overflow_flag_out,
    input wire logic              irq_out,
    input wire logic              watchdog_enable_bit_out,
    input wire logic [N_MOD-1:0]  module_output_pin_out,
    input wire logic              wdt_reset_out
);
    logic [CNT_W-1:0]  cmp0_q;
    logic [MODE_W-1:0] mode0_q;
    logic              pwm0;
    logic              tmr0;

    assign pwm0 = mode0_q[MODE_CEN] & mode0_q[MODE_PULSE] & mode0_q[MODE_P16];
    assign tmr0 = mode0_q[MODE_CEN] & mode0_q[MODE_MAT];

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cmp0_q  <= CMP_RST;
            mode0_q <= MODE_RST;
        end else if (mod_sel_in == 2'h0) begin
            if (wr_cmp_low_in) begin
                cmp0_q[7:0]       <= wr_data_in;
                mode0_q[MODE_CEN] <= 1'b0;
            end
            if (wr_cmp_high_in) begin
                cmp0_q[15:8]      <= wr_data_in;
                mode0_q[MODE_CEN] <= 1'b1;
            end
            if (wr_mode_in) begin
                mode0_q <= mode_data_in;
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    AST_CNT_STEP: assert property ($past(rst_b_in) && $past(rst_b_in, 2) |->
        counter_out == $past(counter_out) + 16'h0001) else $error("counter did not step");
    AST_OVF_SET: assert property (counter_out == CNT_RST && $past(counter_out) == CNT_MAX |->
        ##[0:2] overflow_flag_out) else $error("wrap did not set overflow flag");
    AST_FLAG_HOLD: assert property ((~module_match_flag_out & $past(module_match_flag_out)) != '0 |->
        $past(flag_clr_in)) else $error("match flag dropped without clear");
    AST_IRQ_CAUSE: assert property (irq_out |-> $past(module_match_flag_out) != '0)
        else $error("irq without match flag");
    AST_TIMER_FLAG: assert property (counter_out == cmp0_q && tmr0 |=> module_match_flag_out[0])
        else $error("match did not set flag");
    AST_TIMER_IRQ: assert property (counter_out == cmp0_q && tmr0 && mode0_q[MODE_IE] |-> ##2 irq_out)
        else $error("enabled match did not raise irq");
    AST_PWM_HIGH: assert property (pwm0 && $past(pwm0) && $stable(cmp0_q) && counter_out == cmp0_q
        |-> module_output_pin_out[0]) else $error("pwm pin low on match");
    AST_PWM_LOW: assert property (pwm0 && $past(pwm0) && $stable(cmp0_q) && cmp0_q != CMP_RST
        && counter_out == CNT_RST |-> !module_output_pin_out[0]) else $error("pwm pin high at wrap");
    AST_PWM_OFF: assert property (!pwm0 && !$past(pwm0) |-> !module_output_pin_out[0])
        else $error("pin high outside pwm mode");
    AST_WDT_PULSE: assert property (wdt_reset_out |=> !wdt_reset_out)
        else $error("watchdog reset wider than one cycle");
    AST_WDT_ALIGN: assert property (wdt_reset_out |-> counter_out[7:0] == 8'h00
        && $past(watchdog_enable_bit_out)) else $error("watchdog reset off boundary");
    AST_WDT_ON: assert property (!$past(rst_b_in) |-> watchdog_enable_bit_out)
        else $error("watchdog not enabled after reset");
endmodule // pcw_core_checker

bind pcw_core pcw_core_checker #(.N_MOD(N_MOD)) i_pcw_core_checker (
    .clk_in                  (clk_in),
    .rst_b_in                (rst_b_in),
    .mod_sel_in              (mod_sel_in),
    .wr_data_in              (wr_data_in),
    .wr_cmp_low_in           (wr_cmp_low_in),
    .wr_cmp_high_in          (wr_cmp_high_in),
    .wr_mode_in              (wr_mode_in),
    .mode_data_in            (mode_data_in),
    .flag_clr_in             (flag_clr_in),
    .counter_out             (counter_out),
    .module_match_flag_out   (module_match_flag_out),
    .overflow_flag_out       (overflow_flag_out),
    .irq_out                 (irq_out),
    .watchdog_enable_bit_out (watchdog_enable_bit_out),
    .module_output_pin_out   (module_output_pin_out),
    .wdt_reset_out           (wdt_reset_out)
);

`default_nettype wire

// file: test/pcw_core_test.sv
// Purpose: Self-checking bench for pcw_core
// Assumes: Inputs change at the falling clock edge
// Notes:   One long wait walks the counter up to just before its wrap
`default_nettype none

module pcw_core_test
    import pcw_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    // Inputs
    logic                clk_in;
    logic                rst_b_in;
    logic [SEL_W-1:0]    mod_sel_in;
    logic [BYTE_W-1:0]   wr_data_in;
    logic [MODE_W-1:0]   mode_data_in;
    logic                wr_cmp_low_in, wr_cmp_high_in, wr_mode_in;
    logic                wr_wdt_en_in, wdt_en_data_in, flag_clr_in, ovf_clr_in;
    // Outputs
    logic [CNT_W-1:0]    counter_out;
    logic [NUM_MOD-1:0]  flag, pin;
    logic                ovf, irq, wdt_en, wdt_rst;
    int                  error_cnt = 0;
    int                  n_tests = 0;

    pcw_core i_pcw_core (.clk_in(clk_in), .rst_b_in(rst_b_in), .mod_sel_in(mod_sel_in),
        .wr_data_in(wr_data_in), .wr_cmp_low_in(wr_cmp_low_in), .wr_cmp_high_in(wr_cmp_high_in),
        .wr_mode_in(wr_mode_in), .mode_data_in(mode_data_in), .wr_wdt_en_in(wr_wdt_en_in),
        .wdt_en_data_in(wdt_en_data_in), .flag_clr_in(flag_clr_in), .ovf_clr_in(ovf_clr_in),
        .counter_out(counter_out), .module_match_flag_out(flag), .overflow_flag_out(ovf),
        .irq_out(irq), .watchdog_enable_bit_out(wdt_en), .module_output_pin_out(pin),
        .wdt_reset_out(wdt_rst));

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Kind: 0 low byte, 1 high byte, 2 mode, 3 watchdog enable, 4 flag clear, 5 overflow clear
    task automatic wr_reg(input logic [1:0] s, input int k, input logic [7:0] d);
        mod_sel_in = s;
        wr_data_in = d;
        mode_data_in = d[4:0];
        wdt_en_data_in = d[0];
        {ovf_clr_in, flag_clr_in, wr_wdt_en_in, wr_mode_in, wr_cmp_high_in, wr_cmp_low_in} = 6'(1 << k);
        tick(1);
        {ovf_clr_in, flag_clr_in, wr_wdt_en_in, wr_mode_in, wr_cmp_high_in, wr_cmp_low_in} = 6'h00;
        tick(1);
    endtask

    task automatic wr_cmp16(input logic [1:0] s, input logic [15:0] v);
        wr_reg(s, 0, v[7:0]);
        wr_reg(s, 1, v[15:8]);
    endtask

    task automatic wait_cnt(input logic [15:0] v);
        int i;
        for (i = 0; i < 70000 && counter_out !== v; i++) begin
            tick(1);
        end
        chk("counter reached", counter_out, v);
    endtask

    task automatic t_reset();
        logic [15:0] c;
        chk("wdt enable", 16'(wdt_en), 16'h0001);
        chk("outputs", 16'({flag, ovf, irq, pin, wdt_rst}), 16'h0000);
        c = counter_out;
        tick(1);
        chk("counter step", counter_out, c + 16'h0001);
        wr_reg(2'h0, 3, 8'h00);
        chk("wdt off", 16'(wdt_en), 16'h0000);
    endtask

    // Modes: timer+irq, timer, timer+irq with low-only rewrite, no match detect
    task automatic t_timer();
        logic [4:0]  md [4] = '{5'h13, 5'h03, 5'h13, 5'h11};
        logic [3:0]  ef = 4'b0011;
        logic [3:0]  ei = 4'b0001;
        logic [15:0] t;
        int          i;
        for (i = 0; i < 4; i++) begin
            wr_reg(2'h0, 2, {3'h0, md[i]});
            t = counter_out + 16'h0064;
            wr_cmp16(2'h0, t);
            if (i == 2) begin
                wr_reg(2'h0, 0, t[7:0]);
            end
            wait_cnt(t);
            tick(3);
            chk("match flag", 16'(flag[0]), 16'(ef[i]));
            chk("irq", 16'(irq), 16'(ei[i]));
            tick(20);
            chk("flag held", 16'(flag[0]), 16'(ef[i]));
            wr_reg(2'h0, 4, 8'h00);
            tick(2);
            chk("flag cleared", 16'({flag[0], irq}), 16'h0000);
        end
    endtask

    task automatic t_wdt();
        logic [7:0] h;
        int         i;
        int         seen;
        wr_reg(2'h2, 0, 8'h01);
        wr_reg(2'h0, 3, 8'h01);
        wr_reg(2'h2, 0, 8'h05);
        for (i = 0; i < 300 && counter_out[7:0] !== 8'h10; i++) tick(1);
        h = counter_out[15:8];
        wr_reg(2'h2, 1, 8'h00);
        for (i = 0; i < 600 && wdt_rst !== 1'b1; i++) tick(1);
        chk("wdt trip", 16'(wdt_rst), 16'h0001);
        chk("trip point", counter_out, {h + 8'h01, 8'h00});
        // Rearm so that a trip would fall inside the watch below if disable failed
        wr_reg(2'h2, 1, 8'h00);
        wr_reg(2'h0, 3, 8'h00);
        seen = 0;
        for (i = 0; i < 600; i++) begin
            seen += (wdt_rst === 1'b1);
            tick(1);
        end
        chk("no trip when off", 16'(seen), 16'h0000);
    endtask

    task automatic t_pwm();
        logic [4:0] e0 = 5'b00110;
        logic [4:0] e1 = 5'b11000;
        int         i;
        wr_reg(2'h0, 2, 8'h1F);
        wr_cmp16(2'h0, 16'hFFFE);
        wr_reg(2'h1, 2, 8'h0D);
        wr_cmp16(2'h1, 16'h0000);
        wr_reg(2'h2, 2, 8'h0D);
        wr_reg(2'h2, 0, 8'h00);
        wait_cnt(16'hFFFD);
        for (i = 0; i < 5; i++) begin
            chk("pin FFFE", 16'(pin[0]), 16'(e0[i]));
            chk("pin zero", 16'(pin[1]), 16'(e1[i]));
            chk("pin off", 16'(pin[2]), 16'h0000);
            tick(1);
        end
        chk("overflow", 16'(ovf), 16'h0001);
        chk("pwm match irq", 16'({flag[0], irq}), 16'h0003);
        wr_reg(2'h0, 4, 8'h00);
        wr_cmp16(2'h0, 16'h0100);
        wait_cnt(16'h0100);
        chk("pin new duty", 16'(pin[0]), 16'h0001);
        wr_reg(2'h0, 5, 8'h00);
        chk("overflow clr", 16'(ovf), 16'h0000);
    endtask

    initial begin
        rst_b_in = 1'b0;
        mod_sel_in = '0;
        wr_data_in = '0;
        mode_data_in = '0;
        wdt_en_data_in = 1'b0;
        {ovf_clr_in, flag_clr_in, wr_wdt_en_in, wr_mode_in, wr_cmp_high_in, wr_cmp_low_in} = '0;
        tick(12);
        rst_b_in = 1'b1;
        t_reset();
        t_timer();
        t_wdt();
        t_pwm();
        summarize();
    end

    initial begin
        repeat (90000) @(posedge clk_in);
        error_cnt++;
        summarize();
    end
endmodule // pcw_core_test

`default_nettype wire
